// ==== verification/psa_arbiter_bench.sv ====
// self-checking bench of the power state request arbiter
`timescale 1ns/10ps
module psa_arbiter_bench;
   import psa_pkg::*;
   localparam int TICK = 10;
   typedef struct {int src; logic sleep; logic wide; psa_seq_type sel;}
      psa_row_type;
   logic        clock = 1'b0;
   logic        rst_n, we, re, irq, slow, seq_done, seq_start;
   logic [3:0]  addr, int_event_in;
   logic [31:0] wdata, rdata, d;
   logic        power_button_n_in, hold_on_in, power_down_in, reset_in;
   logic        supply_high_ok, die_hot_event, supply_low_fault;
   logic        thermal_shutdown_in, watchdog_timeout, adc_shutdown_event;
   logic        device_sleep_in, reset_wide, reset_narrow;
   psa_seq_type seq_select;
   int          fail_count, check_count, cycles, waited;
   psa_row_type rows [4] = '{'{SRC_SOFT_RST, 1'b0, 1'b1, SEQ_ACTIVE_TO_OFF},
      '{SRC_THERMAL, 1'b0, 1'b0, SEQ_ACTIVE_TO_OFF},
      '{SRC_SUPPLY_LO, 1'b0, 1'b1, SEQ_ACTIVE_TO_OFF},
      '{SRC_THERMAL, 1'b1, 1'b1, SEQ_SLEEP_TO_OFF}};

   psa_arbiter #(.TICK_CYC(TICK), .DEB_MS(2), .LPRESS_MS(30)) dut (
      .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .we(we),
      .re(re), .rdata(rdata), .irq(irq),
      .power_button_n_in(power_button_n_in), .hold_on_in(hold_on_in),
      .power_down_in(power_down_in), .reset_in(reset_in),
      .supply_high_ok(supply_high_ok), .die_hot_event(die_hot_event),
      .supply_low_fault(supply_low_fault),
      .thermal_shutdown_in(thermal_shutdown_in),
      .watchdog_timeout(watchdog_timeout),
      .adc_shutdown_event(adc_shutdown_event), .int_event_in(int_event_in),
      .device_sleep_in(device_sleep_in), .seq_done(seq_done),
      .seq_start(seq_start), .seq_select(seq_select),
      .reset_wide(reset_wide), .reset_narrow(reset_narrow));
   psa_seq_model model (.clock(clock), .rst_n(rst_n), .seq_start(seq_start),
      .slow(slow), .seq_done(seq_done));

   always #25 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         conclude();
      end
   end
   // ----------------------------------------------------------
   // tasks
   // ----------------------------------------------------------
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      we <= 1'b1;
      cyc(1);
      we <= 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [3:0] a);
      addr <= a;
      re <= 1'b1;
      cyc(1);
      re <= 1'b0;
      d = rdata;
      cyc(1);
   endtask
   task automatic chk_state(input logic [2:0] s);
      rd(ADDR_STATE);
      check(32'(d[2:0]), 32'(s));
   endtask
   task automatic wait_start(input psa_seq_type sel);
      waited = 0;
      while (seq_start !== 1'b1 && waited < 12000) begin
         cyc(1);
         waited++;
      end
      check(32'(seq_start), 32'h1);
      check(32'(seq_select), 32'(sel));
   endtask
   task automatic wait_off(input logic wide);
      int n;
      n = 0;
      while (reset_wide !== 1'b1 && reset_narrow !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      check(32'(reset_wide), 32'(wide));
      check(32'(reset_narrow), 32'(!wide));
   endtask
   task automatic power_up;
      power_button_n_in <= 1'b0;
      wait_start(SEQ_OFF_TO_ACTIVE);
      power_button_n_in <= 1'b1;
      cyc(60);
      chk_state(3'h2);
   endtask
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      {rst_n, we, re, addr, wdata, int_event_in, hold_on_in, slow} <= '0;
      {die_hot_event, supply_low_fault, thermal_shutdown_in} <= 3'h0;
      {watchdog_timeout, adc_shutdown_event, device_sleep_in} <= 3'h0;
      {power_button_n_in, power_down_in, reset_in, supply_high_ok} <= 4'hF;
      cyc(16);
      rst_n <= 1'b1;
      cyc(1);
      for (int i = 0; i < 4; i++) begin
         power_up();
         device_sleep_in <= rows[i].sleep;
         wr(ADDR_LEVEL, 32'(rows[i].wide) << rows[i].src);
         if (rows[i].src == SRC_SOFT_RST) begin
            wr(ADDR_CTRL, 32'h2);
         end
         thermal_shutdown_in <= rows[i].src == SRC_THERMAL;
         supply_low_fault <= rows[i].src == SRC_SUPPLY_LO;
         wait_start(rows[i].sel);
         {thermal_shutdown_in, supply_low_fault, device_sleep_in} <= 3'h0;
         wait_off(rows[i].wide);
         cyc(30);
         chk_state(3'h0);
      end
      supply_high_ok <= 1'b0;
      power_button_n_in <= 1'b0;
      cyc(40);
      chk_state(3'h0);
      rd(ADDR_STATUS);
      check(32'(d[ST_ON_BLOCKED]), 32'h1);
      {supply_high_ok, die_hot_event} <= 2'h3;
      cyc(40);
      chk_state(3'h0);
      die_hot_event <= 1'b0;
      wait_start(SEQ_OFF_TO_ACTIVE);
      cyc(10);
      thermal_shutdown_in <= 1'b1;
      wait_start(SEQ_ACTIVE_TO_OFF);
      wait_off(1'b1);
      cyc(40);
      chk_state(3'h0);
      thermal_shutdown_in <= 1'b0;
      wait_start(SEQ_OFF_TO_ACTIVE);
      power_button_n_in <= 1'b1;
      cyc(60);
      wr(ADDR_ACTION, 32'h1 << SRC_SOFT_RST);
      wr(ADDR_MASK, 32'h6F);
      wr(ADDR_CTRL, 32'h2);
      wait_start(SEQ_ACTIVE_TO_OFF);
      wait_off(1'b0);
      wait_start(SEQ_OFF_TO_ACTIVE);
      check(32'(irq), 32'h1);
      rd(ADDR_STATUS);
      check(32'(d[ST_OFF_DONE]), 32'h1);
      cyc(2);
      check(32'(irq), 32'h0);
      cyc(60);
      wr(ADDR_CONFIG, 32'h1);
      watchdog_timeout <= 1'b1;
      cyc(40);
      chk_state(3'h2);
      slow <= 1'b1;
      wr(ADDR_CTRL, 32'hC);
      wait_start(SEQ_ACTIVE_TO_OFF);
      check(32'(waited > 1000 * TICK - 10 &&
         waited < 1000 * TICK + 30), 32'h1);
      watchdog_timeout <= 1'b0;
      wait_off(1'b0);
      slow <= 1'b0;
      wr(ADDR_CTRL, 32'h0);
      rd(ADDR_CTRL);
      check(d, 32'hC);
      hold_on_in <= 1'b1;
      wait_start(SEQ_OFF_TO_ACTIVE);
      check(32'(waited >= TICK && waited < 4 * TICK), 32'h1);
      cyc(60);
      wr(ADDR_CTRL, 32'hD);
      wr(ADDR_CTRL, 32'hC);
      cyc(40);
      chk_state(3'h2);
      hold_on_in <= 1'b0;
      wait_start(SEQ_ACTIVE_TO_OFF);
      check(32'(waited < 6 * TICK), 32'h1);
      wait_off(1'b0);
      power_up();
      wr(ADDR_CTRL, 32'hD);
      wr(ADDR_CTRL, 32'hC);
      wait_start(SEQ_ACTIVE_TO_OFF);
      wait_off(1'b0);
      wr(ADDR_CONFIG, 32'h0);
      power_button_n_in <= 1'b0;
      wait_start(SEQ_OFF_TO_ACTIVE);
      cyc(1);
      wait_start(SEQ_ACTIVE_TO_OFF);
      check(32'(waited > 25 * TICK), 32'h1);
      wait_off(1'b0);
      power_button_n_in <= 1'b1;
      rst_n <= 1'b0;
      cyc(16);
      rst_n <= 1'b1;
      cyc(1);
      rd(ADDR_CTRL);
      check(d, 32'h0);
      rd(ADDR_MASK);
      check(d, 32'h7F);
      rd(4'hF);
      check(d, 32'h0);
      int_event_in <= 4'h1;
      cyc(20);
      chk_state(3'h0);
      int_event_in <= 4'h0;
      wr(ADDR_MASK, 32'h7E);
      int_event_in <= 4'h1;
      wait_start(SEQ_OFF_TO_ACTIVE);
      conclude();
   end
endmodule

// ==== verification/psa_arbiter_chk.sv ====
// port checker of the power state request arbiter
`timescale 1ns/10ps
module psa_arbiter_chk
   import psa_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic              re,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic              supply_high_ok,
   input wire logic              die_hot_event,
   input wire logic              seq_done,
   input wire logic              seq_start,
   input wire psa_seq_type       seq_select,
   input wire logic              reset_wide,
   input wire logic              reset_narrow
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   a_start_pulse: assert property (seq_start |=> !seq_start)
      else $error("start pulse longer than one cycle");
   a_start_kind: assert property (
      seq_start |-> seq_select != SEQ_NONE)
      else $error("start without a sequence");
   a_select_hold: assert property (
      !seq_start |-> $stable(seq_select))
      else $error("sequence select moved without start");
   a_read_idle: assert property (!$past(re) |-> rdata == '0)
      else $error("read data outside the read answer");
   a_level_excl: assert property (!(reset_wide && reset_narrow))
      else $error("both reset levels at once");
   a_level_cause: assert property (
      (reset_wide || reset_narrow) |-> $past(seq_done))
      else $error("reset level without finished sequence");
   a_supply_gate: assert property (
      !supply_high_ok [*4] |->
      !(seq_start && seq_select == SEQ_OFF_TO_ACTIVE))
      else $error("power up while supply gating");
   a_hot_gate: assert property (
      die_hot_event [*4] |->
      !(seq_start && seq_select == SEQ_OFF_TO_ACTIVE))
      else $error("power up while die hot");
   // ----------------------------------------------------------
   // covers
   // ----------------------------------------------------------
   c_sleep_off: cover property (seq_start && seq_select == SEQ_SLEEP_TO_OFF);
   c_wide: cover property (reset_wide);
   c_narrow: cover property (reset_narrow);
endmodule

bind psa_arbiter psa_arbiter_chk chk (
   .clock(clock), .rst_n(rst_n), .re(re), .rdata(rdata),
   .supply_high_ok(supply_high_ok), .die_hot_event(die_hot_event),
   .seq_done(seq_done), .seq_start(seq_start), .seq_select(seq_select),
   .reset_wide(reset_wide), .reset_narrow(reset_narrow)
);

// ==== verification/psa_seq_model.sv ====
// sequencer model answering the arbiter's start pulses
`timescale 1ns/10ps
module psa_seq_model (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic seq_start,
   input  wire logic slow,
   output logic      seq_done
);
   logic [5:0] count_reg;
   logic       busy_reg;
   // ----------------------------------------------------------
   // a started sequence ends after a short or a long run
   // ----------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy_reg  <= 1'b0;
         count_reg <= 6'h00;
         seq_done  <= 1'b0;
      end else if (seq_start) begin
         busy_reg  <= 1'b1;
         count_reg <= slow ? 6'h28 : 6'h02;
         seq_done  <= 1'b0;
      end else begin
         seq_done  <= busy_reg && count_reg == 6'h00;
         busy_reg  <= busy_reg && count_reg != 6'h00;
         count_reg <= count_reg - ((count_reg != 6'h00) ? 6'h01 : 6'h00);
      end
   end
endmodule

// ==== verilog/psa_arbiter.sv ====
// power state request arbiter: on/off arbitration, gating, delay
//
// How it works
// RULE1: a valid on request in off starts the off-to-active sequence.
// RULE2: unmasked interrupt edges and low power button are on requests.
// RULE3: hold-on high is an on request after a 4 ms debounce.
// RULE4: any gating condition blocks the on request.
// RULE5: gating is low supply, hot die, power-down and reset-in.
// RULE6: an off request runs active-to-off or sleep-to-off.
// RULE7: off requests win over on and sleep, with no gating.
// RULE8: after an off request, on waits until off requests are gone.
// RULE9: one switch-off delay of 0, 1, 2 or 4 s for delayed sources.
// RULE10: each off source selects wide or narrow reset level; the code fixes keep-on and hold-on at narrow.
// RULE11: each off source selects shutdown or cold restart; the code fixes keep-on and hold-on at shutdown.
// RULE12: shutdown runs the off sequence and stays off.
// RULE13: cold restart reruns off-to-active once gating is absent.
// RULE14: watchdog off request disabled at reset; enable can be locked.
// RULE15: clearing keep-on turns off narrow, shutdown, unless hold-on high.
// RULE16: hold-on low turns off narrow, no delay, unless keep-on set.
// RULE17: arbitrate on, off, wake, sleep and hand transition to sequencer; the code arbitrates on and off only, with no wake or sleep.
// RULE18: sample synchronously; off first, then gating, then on.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module psa_arbiter
   import psa_pkg::*;
#(
   parameter int TICK_CYC  = TICK_CYCLES,
   parameter int DEB_MS    = HOLD_DEBOUNCE_MS,
   parameter int LPRESS_MS = LONG_PRESS_MS
) (
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire logic [DATA_W-1:0]   wdata,
   input  wire logic                we,
   input  wire logic                re,
   output logic      [DATA_W-1:0]   rdata,
   output logic                     irq,
   input  wire logic                power_button_n_in,
   input  wire logic                hold_on_in,
   input  wire logic                power_down_in,
   input  wire logic                reset_in,
   input  wire logic                supply_high_ok,
   input  wire logic                die_hot_event,
   input  wire logic                supply_low_fault,
   input  wire logic                thermal_shutdown_in,
   input  wire logic                watchdog_timeout,
   input  wire logic                adc_shutdown_event,
   input  wire logic [INT_EV_W-1:0] int_event_in,
   input  wire logic                device_sleep_in,
   input  wire logic                seq_done,
   output logic                     seq_start,
   output psa_seq_type              seq_select,
   output logic                     reset_wide,
   output logic                     reset_narrow
);

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   localparam int PIN_N = 8;
   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] sync1_reg;
   logic [PIN_N-1:0] sync2_reg;

   assign pin_raw = {thermal_shutdown_in, supply_low_fault, die_hot_event,
                     supply_high_ok, reset_in, power_down_in, hold_on_in,
                     power_button_n_in};

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         // idle pin levels, so no false request or edge follows reset
         sync1_reg <= 8'h1D;
         sync2_reg <= 8'h1D;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   wire button_n_s  = sync2_reg[0];
   wire hold_s      = sync2_reg[1];
   wire pwr_down_s  = sync2_reg[2];
   wire reset_in_s  = sync2_reg[3];
   wire supply_ok_s = sync2_reg[4];
   wire die_hot_s   = sync2_reg[5];
   wire supply_lo_s = sync2_reg[6];
   wire thermal_s   = sync2_reg[7];

   // -----------------------------------------------------------------
   // millisecond tick
   // -----------------------------------------------------------------
   localparam int TW = $clog2(TICK_CYC);
   logic [TW-1:0] tick_cnt_reg;
   wire tick = (tick_cnt_reg == TW'(TICK_CYC - 1));

   always_ff @(posedge clock) begin
      if (!rst_n)
         tick_cnt_reg <= '0;
      else
         tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
   end

   // -----------------------------------------------------------------
   // hold-on debounce and button long press
   // -----------------------------------------------------------------
   logic        hold_db_reg;
   logic        hold_prev_reg;
   logic [3:0]  hold_cnt_reg;
   logic [12:0] press_cnt_reg;

   wire hold_diff  = hold_s != hold_db_reg;
   wire hold_flip  = hold_diff & tick &
                     (hold_cnt_reg == 4'(DEB_MS - 1));
   wire hold_fall  = hold_prev_reg & ~hold_db_reg;
   wire long_press = press_cnt_reg == 13'(LPRESS_MS);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         hold_db_reg   <= 1'b0;
         hold_prev_reg <= 1'b0;
         hold_cnt_reg  <= '0;
      end else begin
         hold_prev_reg <= hold_db_reg;
         if (!hold_diff || hold_flip)
            hold_cnt_reg <= '0;
         else if (tick)
            hold_cnt_reg <= hold_cnt_reg + 1'b1;
         if (hold_flip)
            hold_db_reg <= hold_s;  // [RULE3]
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n || button_n_s)
         press_cnt_reg <= '0;
      else if (tick && !long_press)
         press_cnt_reg <= press_cnt_reg + 1'b1;
   end

   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   logic [CTRL_W-1:0]   ctrl_reg;
   logic [CFG_W-1:0]    cfg_reg;
   logic [OFF_N-1:0]    action_reg;
   logic [OFF_N-1:0]    level_reg;
   logic [STAT_W-1:0]   mask_reg;
   logic [STAT_W-1:0]   status_reg;
   logic [STAT_W-1:0]   status_next;
   logic [STAT_W-1:0]   status_set;
   logic [DATA_W-1:0]   rd_mux;
   psa_state_type       state_reg;
   logic [3:0]          src_reg;

   wire wr_ctrl   = we && addr == ADDR_CTRL;
   wire rd_status = re && addr == ADDR_STATUS;
   wire wdt_lock  = ctrl_reg[CTRL_WDT_LOCK];
   wire keep_on   = ctrl_reg[CTRL_KEEP_ON];
   wire keep_fall = wr_ctrl & keep_on & ~wdata[CTRL_KEEP_ON];
   wire soft_rst  = wr_ctrl & wdata[CTRL_SOFT_RST];

   // locked watchdog bits keep their value
   wire [1:0] wdt_bits = wdt_lock ?
                         ctrl_reg[CTRL_WDT_LOCK:CTRL_WDT_EN] :
                         wdata[CTRL_WDT_LOCK:CTRL_WDT_EN];  // [RULE14]
   wire [CTRL_W-1:0] ctrl_wr = {wdata[CTRL_ADC_EN], wdt_bits, 1'b0,
                                wdata[CTRL_KEEP_ON]};

   assign rd_mux =
      addr == ADDR_CTRL   ? DATA_W'(ctrl_reg)   :
      addr == ADDR_CONFIG ? DATA_W'(cfg_reg)    :
      addr == ADDR_ACTION ? DATA_W'(action_reg) :
      addr == ADDR_LEVEL  ? DATA_W'(level_reg)  :
      addr == ADDR_MASK   ? DATA_W'(mask_reg)   :
      addr == ADDR_STATUS ? DATA_W'(status_reg) :
      addr == ADDR_STATE  ? DATA_W'({src_reg, 1'b0, state_reg}) :
      '0;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_reg   <= CTRL_RESET;
         cfg_reg    <= CFG_RESET;
         action_reg <= ACTION_RESET;
         level_reg  <= LEVEL_RESET;
         mask_reg   <= MASK_RESET;  // [RULE2]
         rdata      <= '0;
      end else begin
         rdata <= re ? rd_mux : '0;
         if (wr_ctrl)
            ctrl_reg <= ctrl_wr;
         if (we && addr == ADDR_CONFIG)
            cfg_reg <= wdata[CFG_W-1:0];
         if (we && addr == ADDR_ACTION)
            action_reg <= wdata[OFF_N-1:0];
         if (we && addr == ADDR_LEVEL)
            level_reg <= wdata[OFF_N-1:0];
         if (we && addr == ADDR_MASK)
            mask_reg <= wdata[STAT_W-1:0];
      end
   end

   // -----------------------------------------------------------------
   // request evaluation
   // -----------------------------------------------------------------
   logic [INT_EV_W-1:0] ev_prev_reg;
   logic [OFF_N-1:0]    off_lvl;
   logic [3:0]          off_pick;

   wire [INT_EV_W-1:0] ev_edge = int_event_in & ~ev_prev_reg;
   wire pd_act  = pwr_down_s == cfg_reg[CFG_PD_POL];
   wire rst_act = reset_in_s == cfg_reg[CFG_RST_POL];
   wire gate    = ~supply_ok_s | die_hot_s | pd_act | rst_act;  // [RULE5]
   wire int_on  = |(ev_edge & ~mask_reg[INT_EV_W-1:0]);  // [RULE2]
   wire on_req  = ~button_n_s | hold_db_reg | int_on;  // [RULE2] [RULE3]

   assign off_lvl[SRC_BUTTON]    = long_press;
   assign off_lvl[SRC_PWR_DOWN]  = pd_act;
   assign off_lvl[SRC_WATCHDOG]  = ctrl_reg[CTRL_WDT_EN] &
                                   watchdog_timeout;  // [RULE14]
   assign off_lvl[SRC_THERMAL]   = thermal_s;
   assign off_lvl[SRC_RESET_IN]  = rst_act;
   assign off_lvl[SRC_SOFT_RST]  = soft_rst;
   assign off_lvl[SRC_KEEP_ON]   = keep_fall & ~hold_db_reg;  // [RULE15]
   assign off_lvl[SRC_SUPPLY_LO] = supply_lo_s;
   assign off_lvl[SRC_HOLD_ON]   = hold_fall & ~keep_on;  // [RULE16]
   assign off_lvl[SRC_ADC]       = ctrl_reg[CTRL_ADC_EN] &
                                   adc_shutdown_event;

   wire off_any = |off_lvl;

   always_comb begin
      off_pick = 4'h0;
      for (int i = OFF_N - 1; i >= 0; i--)
         if (off_lvl[i])
            off_pick = 4'(i);
   end

   wire fixed_src = off_pick == 4'(SRC_KEEP_ON) ||
                    off_pick == 4'(SRC_HOLD_ON);
   wire pick_cold = ~fixed_src & action_reg[off_pick];  // [RULE11]
   wire pick_wide = ~fixed_src & level_reg[off_pick];  // [RULE10]

   logic [12:0] dly_ms;
   always_comb begin
      case (cfg_reg[CFG_DLY_LSB+1:CFG_DLY_LSB])
         2'h0:    dly_ms = DLY_0_MS;
         2'h1:    dly_ms = DLY_1_MS;
         2'h2:    dly_ms = DLY_2_MS;
         default: dly_ms = DLY_4_MS;
      endcase
   end
   wire [12:0] pick_dly = OFF_USES_DELAY[off_pick] ? dly_ms : DLY_0_MS;

   // -----------------------------------------------------------------
   // power state machine
   // -----------------------------------------------------------------
   psa_state_type state_next;
   logic        cold_reg;
   logic        wide_reg;
   logic [12:0] dly_cnt_reg;

   wire in_off    = state_reg == ST_OFF;
   wire start_up  = in_off & ~gate & (cold_reg | (~off_any & on_req));
   wire off_take  = state_reg == ST_ACTIVE & off_any;  // [RULE7]
   wire dly_end   = state_reg == ST_DELAY & dly_cnt_reg == DLY_0_MS;
   wire down_done = state_reg == ST_DOWN & seq_done;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF:    if (start_up) state_next = ST_UP;  // [RULE1] [RULE8]
         ST_UP:     if (seq_done) state_next = ST_ACTIVE;
         ST_ACTIVE: if (off_any) state_next = ST_DELAY;  // [RULE6]
         ST_DELAY:  if (dly_end) state_next = ST_DOWN;
         ST_DOWN:   if (seq_done) state_next = ST_OFF;  // [RULE12]
         default:   state_next = ST_OFF;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg   <= ST_OFF;
         src_reg     <= '0;
         cold_reg    <= 1'b0;
         wide_reg    <= 1'b0;
         dly_cnt_reg <= '0;
         ev_prev_reg <= '0;
      end else begin
         state_reg   <= state_next;
         ev_prev_reg <= int_event_in;
         if (off_take) begin
            src_reg     <= off_pick;
            cold_reg    <= pick_cold;
            wide_reg    <= pick_wide;
            dly_cnt_reg <= pick_dly;  // [RULE9]
         end else if (state_reg == ST_DELAY && tick && !dly_end)
            dly_cnt_reg <= dly_cnt_reg - 1'b1;
         if (start_up)
            cold_reg <= 1'b0;  // [RULE13]
      end
   end

   // -----------------------------------------------------------------
   // sequencer handshake and reset level pulses
   // -----------------------------------------------------------------
   wire psa_seq_type down_sel = device_sleep_in ? SEQ_SLEEP_TO_OFF :
                                SEQ_ACTIVE_TO_OFF;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         seq_start    <= 1'b0;
         seq_select   <= SEQ_NONE;
         reset_wide   <= 1'b0;
         reset_narrow <= 1'b0;
      end else begin
         seq_start    <= start_up | dly_end;  // [RULE17]
         reset_wide   <= down_done & wide_reg;  // [RULE10]
         reset_narrow <= down_done & ~wide_reg;
         if (start_up)
            seq_select <= SEQ_OFF_TO_ACTIVE;
         else if (dly_end)
            seq_select <= down_sel;  // [RULE6] [RULE18]
      end
   end

   // -----------------------------------------------------------------
   // interrupt status, read clears, set wins
   // -----------------------------------------------------------------
   assign status_set = {state_reg == ST_UP && seq_done,
                        in_off & on_req & gate & ~off_any,  // [RULE4]
                        down_done, ev_edge};
   assign status_next = (status_reg & ~{STAT_W{rd_status}}) | status_set;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         status_reg <= '0;
         irq        <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq        <= |(status_next & ~mask_reg);
      end
   end

endmodule

// ==== verilog/psa_pkg.sv ====
// constants and types of the power state request arbiter
package psa_pkg;

   // -----------------------------------------------------------------
   // register bus
   // -----------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_CONFIG  = 4'h1;
   localparam logic [3:0] ADDR_ACTION  = 4'h2;
   localparam logic [3:0] ADDR_LEVEL   = 4'h3;
   localparam logic [3:0] ADDR_MASK    = 4'h4;
   localparam logic [3:0] ADDR_STATUS  = 4'h5;
   localparam logic [3:0] ADDR_STATE   = 4'h6;

   // control register fields
   localparam int CTRL_KEEP_ON  = 0;
   localparam int CTRL_SOFT_RST = 1;
   localparam int CTRL_WDT_EN   = 2;
   localparam int CTRL_WDT_LOCK = 3;
   localparam int CTRL_ADC_EN   = 4;
   localparam int CTRL_W        = 5;
   localparam logic [4:0] CTRL_RESET = 5'h00;

   // power unit config fields
   localparam int CFG_DLY_LSB   = 0;
   localparam int CFG_PD_POL    = 2;
   localparam int CFG_RST_POL   = 3;
   localparam int CFG_W         = 4;
   localparam logic [3:0] CFG_RESET = 4'h0;

   // interrupt status fields
   localparam int INT_EV_W      = 4;
   localparam int ST_OFF_DONE   = 4;
   localparam int ST_ON_BLOCKED = 5;
   localparam int ST_ACTIVE_UP  = 6;
   localparam int STAT_W        = 7;
   localparam logic [6:0] MASK_RESET = 7'h7F;

   // off request sources, lowest index wins
   localparam int OFF_N         = 10;
   localparam int SRC_BUTTON    = 0;
   localparam int SRC_PWR_DOWN  = 1;
   localparam int SRC_WATCHDOG  = 2;
   localparam int SRC_THERMAL   = 3;
   localparam int SRC_RESET_IN  = 4;
   localparam int SRC_SOFT_RST  = 5;
   localparam int SRC_KEEP_ON   = 6;
   localparam int SRC_SUPPLY_LO = 7;
   localparam int SRC_HOLD_ON   = 8;
   localparam int SRC_ADC       = 9;
   localparam logic [9:0] OFF_USES_DELAY = 10'h217;
   localparam logic [9:0] ACTION_RESET   = 10'h000;
   localparam logic [9:0] LEVEL_RESET    = 10'h000;

   // timing
   localparam int CLK_PERIOD_NS   = 50;
   localparam int TICK_TIME_NS    = 1000000;
   localparam int TICK_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int HOLD_DEBOUNCE_MS = 4;
   localparam int LONG_PRESS_MS   = 3000;
   localparam logic [12:0] DLY_0_MS = 13'h0000;
   localparam logic [12:0] DLY_1_MS = 13'h03E8;
   localparam logic [12:0] DLY_2_MS = 13'h07D0;
   localparam logic [12:0] DLY_4_MS = 13'h0FA0;

   typedef enum logic [2:0] {
      ST_OFF, ST_UP, ST_ACTIVE, ST_DELAY, ST_DOWN
   } psa_state_type;

   typedef enum logic [1:0] {
      SEQ_NONE, SEQ_OFF_TO_ACTIVE, SEQ_ACTIVE_TO_OFF, SEQ_SLEEP_TO_OFF
   } psa_seq_type;

endpackage
